// *** shared/pds_pkg.sv ***
package pds_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ = 20;
  // time for one polarity detection pass, in microseconds
  localparam int DET_TIME_US = 100;
  localparam int DET_CYCLES = DET_TIME_US * CLK_MHZ;
  localparam int DET_CNT_W = 12;
  localparam logic [DET_CNT_W-1:0] DET_LAST = DET_CNT_W'(DET_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

  // control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_ALLOC_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_PDET_ON_BIT = 2;
  localparam int CTRL_PHASE_BIT = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  // status register fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_POWER_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_DETECT_BIT = 3;
  localparam int STAT_SONOK_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  localparam int PIN_W = 9;

  typedef struct packed {
    logic servoOn;
    logic polarityDetectIn;
    logic mainPower;
    logic hwBaseblock;
    logic servoAlarm;
    logic fwdLimitIn;
    logic revLimitIn;
    logic refForward;
    logic refStep;
  } pds_pins_s;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
  } pds_avs_req_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DETECT = 3'b010,
    ST_RUN = 3'b100
  } pds_state_e;

endpackage : pds_pkg

// *** logic/pds_enc_out.sv ***
`timescale 1ns/1ns
// quadrature encoder output: counting up gives phase B leading
module pds_enc_out
  import pds_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stepPulse,
  input wire logic countUp,
  output logic encOutA,
  output logic encOutB
);

  logic [1:0] phase_r;

  // quarter-cycle position, moved one step per motion pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_r <= 2'h0;
    end else if (stepPulse) begin
      phase_r <= countUp ? phase_r + 2'h1 : phase_r - 2'h1;
    end
  end

  // gray decode kept in flops so the pins never glitch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      encOutA <= 1'b0;
      encOutB <= 1'b0;
    end else begin
      encOutA <= phase_r[1];
      encOutB <= phase_r[1] ^ phase_r[0];
    end
  end

endmodule : pds_enc_out

// *** logic/pds_sequencer.sv ***
`timescale 1ns/1ns
// Behaviour
// - motor may run normally only after polarity detection has completed
// - servo-on accepted only with main power, no baseblock, no alarm
// - allocation option 0: servo-on starts polarity detection
// - option 0: ready after detection, motor power stays on with servo-on
// - dropping servo-on removes motor power until servo-on returns
// - option 1: motor power on while polarity-detect input is active
// - detection runs once, on first polarity-detect activation
// - option 1: at detection end, power goes off, then ready rises
// - after completion, polarity-detect toggling is ignored
// - control power cycle clears the detection-completed state
// - polarity-detect set always active starts detection with main power
// - direction setting reverses movement, encoder polarity unchanged
// - default: forward reference moves forward, B leads; reverse A leads
// - reversed: forward reference moves backward, encoder still B leads
module pds_sequencer
  import pds_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire pds_pins_s pins,
  input wire pds_avs_req_s avsReq,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic motorPower,
  output logic servoReady,
  output logic motorStep,
  output logic motorForward,
  output logic encOutA,
  output logic encOutB
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [PIN_W-1:0] syncA_r;
  logic [PIN_W-1:0] syncB_r;
  pds_pins_s pinS;
  logic stepPrev_r;

  // every pin is asynchronous to clk, so each bit passes two flops
  for (genvar gi = 0; gi < PIN_W; gi++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        syncA_r[gi] <= 1'b0;
        syncB_r[gi] <= 1'b0;
      end else begin
        syncA_r[gi] <= pins[gi];
        syncB_r[gi] <= syncA_r[gi];
      end
    end
  end

  assign pinS = pds_pins_s'(syncB_r);

  ////////////////////////////////////////////////////////////////////////////
  // register file state

  logic [CTRL_W-1:0] ctrl_r;
  logic waitReq_r;
  logic [31:0] readdata_r;
  logic reqAny;
  logic accept;
  logic [31:0] rdMux;

  // settings used by the sequencer
  logic allocSel;
  logic dirSel;
  logic pdetOn;

  assign allocSel = ctrl_r[CTRL_ALLOC_BIT];
  assign dirSel = ctrl_r[CTRL_DIR_BIT];
  assign pdetOn = ctrl_r[CTRL_PDET_ON_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state

  pds_state_e state_r;
  logic detDone_r;
  logic [DET_CNT_W-1:0] detCnt_r;
  logic motorPower_r;
  logic servoReady_r;
  logic motorStep_r;
  logic motorForward_r;
  logic encUp_r;

  logic condOk;
  logic servoOnOk;
  logic pdetReq;
  logic detTrigger;
  logic startDetect;
  logic abortDetect;
  logic detLast;
  logic stepEdge;
  logic moveAllowed;

  // servo-on counts only while the drive is able to take it
  assign condOk = pinS.mainPower & ~pinS.hwBaseblock & ~pinS.servoAlarm;
  assign servoOnOk = pinS.servoOn & condOk;

  // a polarity-detect input set always active acts as a held level
  assign pdetReq = pinS.polarityDetectIn | pdetOn;

  // option 0 runs detection from servo-on, option 1 from its own input
  assign detTrigger = allocSel ? pdetReq : pinS.servoOn;

  // done flag blocks any further start until the next power-up
  assign startDetect = ~detDone_r & condOk & detTrigger;
  assign abortDetect = ~condOk | ~detTrigger;
  assign detLast = (detCnt_r == DET_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // sequence state machine

  // an aborted pass leaves done clear, so a later trigger retries it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (startDetect) begin
            state_r <= ST_DETECT;
          end else if (detDone_r && servoOnOk) begin
            state_r <= ST_RUN;
          end
        end
        ST_DETECT: begin
          if (abortDetect) begin
            state_r <= ST_IDLE;
          end else if (detLast) begin
            // option 1 drops power first; option 0 keeps it with servo-on
            state_r <= allocSel ? ST_IDLE : ST_RUN;
          end
        end
        ST_RUN: begin
          if (!servoOnOk) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // detection timer, restarted on every entry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      detCnt_r <= '0;
    end else if (state_r == ST_DETECT) begin
      detCnt_r <= detCnt_r + DET_CNT_W'(1);
    end else begin
      detCnt_r <= '0;
    end
  end

  // completion is remembered until control power goes away
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      detDone_r <= 1'b0;
    end else if (state_r == ST_DETECT && detLast && !abortDetect) begin
      detDone_r <= 1'b1;
    end
  end

  // motor power follows the state one cycle late
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      motorPower_r <= 1'b0;
    end else begin
      motorPower_r <= (state_r == ST_DETECT) || (state_r == ST_RUN);
    end
  end

  // ready waits until power from an option 1 pass has really gone off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      servoReady_r <= 1'b0;
    end else begin
      servoReady_r <= detDone_r && condOk &&
        (state_r == ST_RUN || !motorPower_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // motion path

  assign stepEdge = pinS.refStep & ~stepPrev_r;
  // limits belong to the reference direction, not the physical one
  assign moveAllowed = pinS.refForward ? pinS.fwdLimitIn : pinS.revLimitIn;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stepPrev_r <= 1'b0;
    end else begin
      stepPrev_r <= pinS.refStep;
    end
  end

  // steps pass only in normal operation with power on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      motorStep_r <= 1'b0;
      motorForward_r <= 1'b1;
      encUp_r <= 1'b1;
    end else begin
      motorStep_r <= stepEdge && moveAllowed && motorPower_r &&
        state_r == ST_RUN;
      motorForward_r <= pinS.refForward ^ dirSel;
      encUp_r <= pinS.refForward;
    end
  end

  // encoder output tracks the reference, so reversing never flips it
  pds_enc_out u_enc (
    .clk(clk),
    .rst_n(rst_n),
    .stepPulse(motorStep_r),
    .countUp(encUp_r),
    .encOutA(encOutA),
    .encOutB(encOutB)
  );

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer

  assign reqAny = avsReq.read | avsReq.write;
  assign accept = reqAny & ~waitReq_r;

  always_comb begin
    rdMux = 32'h0;
    unique case (avsReq.address)
      REG_CTRL: begin
        rdMux[CTRL_W-1:0] = ctrl_r;
      end
      REG_STATUS: begin
        rdMux[STAT_READY_BIT] = servoReady_r;
        rdMux[STAT_POWER_BIT] = motorPower_r;
        rdMux[STAT_DONE_BIT] = detDone_r;
        rdMux[STAT_DETECT_BIT] = state_r == ST_DETECT;
        rdMux[STAT_SONOK_BIT] = servoOnOk;
      end
      default: begin
        rdMux = 32'h0;
      end
    endcase
  end

  // waitrequest idles high and drops for exactly one cycle per access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitReq_r <= 1'b1;
      readdata_r <= 32'h0;
    end else begin
      waitReq_r <= !(reqAny && waitReq_r);
      if (reqAny && waitReq_r && avsReq.read) begin
        readdata_r <= rdMux;
      end
    end
  end

  // settings may change any time; a mid-pass change takes effect at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (accept && avsReq.write && avsReq.address == REG_CTRL) begin
      ctrl_r <= avsReq.writedata[CTRL_W-1:0];
    end
  end

  assign readdata = readdata_r;
  assign waitrequest = waitReq_r;
  assign motorPower = motorPower_r;
  assign servoReady = servoReady_r;
  assign motorStep = motorStep_r;
  assign motorForward = motorForward_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_run_needs_done: assert property (
    state_r == ST_RUN |-> detDone_r)
    else $error("run state entered without completed detection");

  a_son_gate: assert property (
    $rose(state_r == ST_RUN) |-> $past(servoOnOk))
    else $error("servo-on taken without power, or under baseblock or alarm");

  a_son_starts: assert property (
    !allocSel && state_r == ST_IDLE && !detDone_r && servoOnOk
    |=> state_r == ST_DETECT ##1 motorPower_r)
    else $error("servo-on did not start detection");

  a_son_ready: assert property (
    state_r == ST_RUN && condOk |=> servoReady_r && motorPower_r)
    else $error("ready or power missing in run");

  a_son_drop: assert property (
    state_r == ST_RUN && !pinS.servoOn |=> state_r == ST_IDLE ##1
    !motorPower_r)
    else $error("motor power kept after servo-on dropped");

  a_pdet_power: assert property (
    allocSel && state_r == ST_DETECT |=> motorPower_r)
    else $error("no motor power during detection");

  a_single_pass: assert property (
    detDone_r |=> state_r != ST_DETECT)
    else $error("detection restarted after completion");

  a_pdet_finish: assert property (
    allocSel && state_r == ST_DETECT && detLast && !abortDetect
    |=> !servoReady_r ##1 !motorPower_r && !servoReady_r)
    else $error("power not off before ready after detection");

  a_always_start: assert property (
    allocSel && pdetOn && state_r == ST_IDLE && !detDone_r && condOk
    |=> state_r == ST_DETECT)
    else $error("always-active detect did not start");

  a_ready_done: assert property (
    servoReady_r |-> detDone_r)
    else $error("ready raised before detection completed");

  a_dir_map: assert property (
    motorStep_r |-> motorForward_r == ($past(pinS.refForward) ^
    $past(dirSel)) && encUp_r == $past(pinS.refForward))
    else $error("direction mapping wrong");

  a_limit_gate: assert property (
    motorStep_r |-> $past(moveAllowed))
    else $error("step passed against an active limit");

  a_bus_answer: assert property (
    reqAny && waitReq_r |=> !waitReq_r ##1 waitReq_r)
    else $error("bus answer not one cycle after request");

endmodule : pds_sequencer

// *** testbench/pds_host_model.sv ***
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// host controller model: drives the discrete sequence inputs
module pds_host_model
  import pds_pkg::*;
(
  input wire logic clk,
  input wire pds_pins_s cmd,
  input wire logic waitReady,
  input wire logic servoReady,
  input wire logic stepGo,
  output pds_pins_s pins
);
  logic [2:0] stepCnt_r;
  pds_pins_s pinsNxt;

  initial pins = '0;
  // known counter from time zero, so the step pin never starts unknown
  initial stepCnt_r = 3'h0;

  // servo-on waits for ready if asked; the step level comes from the burst
  always_comb begin
    pinsNxt = cmd;
    pinsNxt.servoOn = cmd.servoOn & (~waitReady | servoReady);
    pinsNxt.refStep = stepCnt_r[2]; // one step edge per eight cycles
  end

  // whole pin word updated once, only after an edge
  always @(posedge clk) begin
    pins <= pinsNxt;
  end

  // step train counter, restarts so each burst gives a known count
  always @(posedge clk) begin
    stepCnt_r <= stepGo ? stepCnt_r + 3'h1 : 3'h0;
  end
endmodule : pds_host_model

// *** testbench/polarity_detect_sequencer_test.sv ***
`timescale 1ns/1ns
module polarity_detect_sequencer_test
  import pds_pkg::*;
;
  logic clk, rst_n, waitReady, stepGo, fwd;
  pds_pins_s cmd, pins;
  pds_avs_req_s avsReq;
  logic [31:0] readdata, rd;
  logic waitrequest, motorPower, servoReady, motorStep, motorForward;
  logic encOutA, encOutB;
  logic [1:0] q0;
  int err_total, samples_checked, seed, n, steps;
  logic [8:0] bad [3] = '{9'h040, 9'h020, 9'h010};
  logic [8:0] lim [4] = '{9'h146, 9'h144, 9'h14A, 9'h148};
  int limExp [4] = '{0, 1, 1, 0};

  pds_sequencer i_pds_sequencer (.clk(clk), .rst_n(rst_n), .pins(pins),
    .avsReq(avsReq), .readdata(readdata), .waitrequest(waitrequest),
    .motorPower(motorPower), .servoReady(servoReady),
    .motorStep(motorStep), .motorForward(motorForward),
    .encOutA(encOutA), .encOutB(encOutB));

  pds_host_model i_pds_host_model (.clk(clk), .cmd(cmd),
    .waitReady(waitReady), .servoReady(servoReady), .stepGo(stepGo),
    .pins(pins));

  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // count step pulses passed to the motor
  always @(posedge clk) begin
    if (motorStep === 1'b1) steps++;
  end

  // expected quadrature state after one count up or down
  function automatic logic [1:0] qnext(input logic [1:0] q, input logic up);
    logic [1:0] b;
    b = {q[1], q[1] ^ q[0]};
    b = up ? b + 2'h1 : b - 2'h1;
    return {b[1], b[1] ^ b[0]};
  endfunction : qnext

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // one bus access; the request is held until waitrequest is seen low,
  // with no assumed latency: only the watchdog ends a hung access
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    avsReq <= '{~wr, wr, a, d};
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = readdata;
    avsReq <= '0;
    @(posedge clk);
  endtask : bus

  // wait for motorPower (s=0) or servoReady (s=1); n counts the edges
  task automatic waitfor(input int s, input logic v, input int lmt);
    for (n = 0; n < lmt; n++) begin
      @(posedge clk);
      if ((s ? servoReady : motorPower) === v) break;
    end
  endtask : waitfor

  // one reference step burst with the given pin pattern
  task automatic dostep(input logic [8:0] c);
    cmd <= c;
    cyc(6);
    q0 = {encOutA, encOutB};
    n = steps;
    stepGo <= 1'b1;
    cyc(8);
    stepGo <= 1'b0;
    cyc(8);
  endtask : dostep

  task automatic finish_test;
    $display("mismatches %0d, checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // watchdog, well beyond two detection passes
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin word: servoOn det main hb alarm fwdLim revLim refFwd step
  initial begin
    seed = 32'h39F4;
    rst_n = 1'b0;
    cmd = 9'h000;
    avsReq = '0;
    waitReady = 1'b0;
    stepGo = 1'b0;
    cyc(12);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({motorPower, servoReady, motorForward, encOutA, encOutB}, 5'h04);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    bus(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    fwd = 1'b0;
    n = $random(seed) & 32'hFFFF_FFF8;
    bus(1'b1, REG_CTRL, n);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd, n & 32'hF);
    // servo-on refused while any one condition is broken
    foreach (bad[i]) begin
      cmd <= 9'h14C ^ bad[i];
      cyc(12);
      chk(motorPower, 1'b0);
    end
    // option 0: servo-on starts detection, ready after the full pass
    cmd <= 9'h14C;
    waitfor(0, 1'b1, 10);
    chk(n < 10, 1'b1);
    waitfor(1, 1'b1, DET_CYCLES + 10);
    chk(n >= DET_CYCLES - 3 && n < DET_CYCLES + 4, 1'b1);
    chk(motorPower, 1'b1);
    // direction setting: motion flips, encoder follows the reference
    for (int d = 0; d < 2; d++) begin
      bus(1'b1, REG_CTRL, d << 1);
      repeat (6) begin
        fwd = $random(seed);
        dostep({7'h53, fwd, 1'b0});
        chk(steps - n, 1);
        chk(motorForward, fwd ^ d[0]);
        chk({encOutA, encOutB}, qnext(q0, fwd));
      end
    end
    // each limit gates only its own reference direction
    foreach (lim[i]) begin
      dostep(lim[i]);
      chk(steps - n, limExp[i]);
      chk({encOutA, encOutB}, limExp[i] ? qnext(q0, lim[i][1]) : q0);
    end
    cmd <= 9'h04C;
    waitfor(0, 1'b0, 10);
    chk(n < 10, 1'b1);
    cmd <= 9'h14C;
    waitfor(0, 1'b1, 10);
    chk(n < 10, 1'b1);
    // control power cycle forgets the finished detection
    cmd <= 9'h04C;
    rst_n <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[STAT_DONE_BIT], 1'b0);
    chk(servoReady, 1'b0);
    // option 1: detect input runs it, host waits for ready
    bus(1'b1, REG_CTRL, 32'h1);
    waitReady <= 1'b1;
    cmd <= 9'h1CC;
    waitfor(0, 1'b1, 10);
    chk(n < 10, 1'b1);
    waitfor(0, 1'b0, DET_CYCLES + 10);
    chk(n >= DET_CYCLES - 3 && n < DET_CYCLES + 4, 1'b1);
    chk(servoReady, 1'b0);
    waitfor(1, 1'b1, 5);
    chk(n < 5, 1'b1);
    waitfor(0, 1'b1, 10);
    chk(n < 10, 1'b1);
    cmd <= 9'h04C;
    cyc(8);
    cmd <= 9'h0CC;
    cyc(12);
    chk(motorPower, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[STAT_DETECT_BIT], 1'b0);
    // detect input always active: main power alone starts it
    waitReady <= 1'b0;
    cmd <= 9'h00C;
    rst_n <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(1);
    bus(1'b1, REG_CTRL, 32'h5);
    cyc(10);
    chk(motorPower, 1'b0);
    cmd <= 9'h04C;
    waitfor(0, 1'b1, 10);
    chk(n < 10, 1'b1);
    finish_test();
  end
endmodule : polarity_detect_sequencer_test
